// File: logic/lgc_cell.sv
// one configurable logic cell with its apb register slave
//
// Our own choices: the APB register port and the placing of the registers.
`default_nettype none
module lgc_cell
  import lgc_pkg::*;
(
  input  wire  logic                      clk,
  input  wire  logic                      rstn,
  input  wire  logic                      psel,
  input  wire  logic                      penable,
  input  wire  logic                      pwrite,
  input  wire  logic [lgc_pkg::ADDR_W-1:0] paddr,
  input  wire  logic [31:0]               pwdata,
  output logic [31:0]                     prdata,
  output logic                            pready,
  output logic                            pslverr,
  input  wire  logic                      inputPinA,
  input  wire  logic                      inputPinB,
  input  wire  logic                      timer3Match,
  input  wire  logic                      timer2Match,
  input  wire  logic                      timer2Output,
  input  wire  logic                      timer3Output,
  input  wire  logic                      multiTimerMatch,
  input  wire  logic                      multiTimerOutA,
  input  wire  logic                      multiTimerOutB,
  input  wire  logic                      multiTimerOutC,
  input  wire  logic                      calendarEvent,
  input  wire  logic                      serialDataIn,
  input  wire  logic                      serialDataOut,
  input  wire  logic                      uartRxIn,
  input  wire  logic                      uartTxOut,
  input  wire  logic                      comparator1Out,
  input  wire  logic                      comparator2Out,
  input  wire  logic                      adcEocEvent,
  input  wire  logic                      referenceClockOut,
  input  wire  logic                      lowPowerRcClock,
  input  wire  logic                      secondaryOscillator,
  input  wire  logic                      otherCellOut,
  output logic                            cellOutput,
  output logic                            pinOutputEnable,
  output logic                            cellIrq
);
  import lgc_pkg::*;

  lgc_state_t q;       // registered state
  lgc_state_t s;       // next state
  logic [3:0] src;     // mux outputs, bit 0 is source 1
  logic [3:0] gate;    // gate outputs after polarity
  logic [7:0] pairs;   // true/negated source pairs
  logic       clkRise; // rising edge of gate 1
  logic       comb;    // function result before polarity
  logic       nextOut; // next final output
  logic       access;  // apb access phase
  logic [1:0] op;      // sub-word operation
  logic [31:0] cur;    // addressed register
  logic [31:0] wmask;  // its writable bits
  logic [31:0] newv;   // value after operation
  logic       hit;     // address decodes

  // apply a write, clear, set or invert to the writable bits only
  function automatic logic [31:0] apply(input logic [31:0] c, input logic [31:0] w,
                                        input logic [31:0] m, input logic [1:0] o);
    logic [31:0] v;
    v = w;
    case (o)
      OP_CLR:  v = c & ~w;
      OP_SET:  v = c | w;
      OP_INV:  v = c ^ w;
      default: v = w;
    endcase
    return (c & ~m) | (v & m);
  endfunction

  // input multiplexers, gates and core function
  always_comb begin
    s = q;
    // mux 1
    case (q.sel[SEL_DS1 +: 3])
      3'h7:    src[0] = multiTimerOutC;
      3'h6:    src[0] = multiTimerOutB;
      3'h5:    src[0] = multiTimerOutA;
      3'h4:    src[0] = referenceClockOut;
      3'h3:    src[0] = lowPowerRcClock;
      3'h2:    src[0] = secondaryOscillator;
      3'h1:    src[0] = q.sysPhase;
      default: src[0] = inputPinA;
    endcase
    // mux 2, reserved codes read as zero
    case (q.sel[SEL_DS2 +: 3])
      3'h6:    src[1] = multiTimerMatch;
      3'h4:    src[1] = adcEocEvent;
      3'h3:    src[1] = uartTxOut;
      3'h2:    src[1] = comparator1Out;
      3'h1:    src[1] = otherCellOut;
      3'h0:    src[1] = inputPinB;
      default: src[1] = 1'b0;
    endcase
    // mux 3, code 001 feeds back the cell's own output
    case (q.sel[SEL_DS3 +: 3])
      3'h7:    src[2] = timer3Match;
      3'h6:    src[2] = timer2Match;
      3'h5:    src[2] = timer2Output;
      3'h4:    src[2] = uartRxIn;
      3'h3:    src[2] = serialDataOut;
      3'h2:    src[2] = comparator2Out;
      3'h1:    src[2] = q.cellOut;
      default: src[2] = inputPinA;
    endcase
    // mux 4; which serial port and which partner cell is set by instance wiring
    case (q.sel[SEL_DS4 +: 3])
      3'h7:    src[3] = timer3Match;
      3'h6:    src[3] = multiTimerMatch;
      3'h5:    src[3] = calendarEvent;
      3'h3:    src[3] = serialDataIn;
      3'h2:    src[3] = timer3Output;
      3'h1:    src[3] = otherCellOut;
      3'h0:    src[3] = inputPinB;
      default: src[3] = 1'b0;
    endcase
    // byte order per gate: source 4 true down to source 1 negated
    pairs = {src[3], ~src[3], src[2], ~src[2], src[1], ~src[1], src[0], ~src[0]};
    for (int i = 0; i < 4; i++) begin
      gate[i] = (|(q.gls[8*i +: 8] & pairs)) ^ q.ctrl[CTRL_GPOL + i];
    end
    // clocked modes use gate 1 edges seen at the system clock
    clkRise = gate[0] & ~q.clkPrev;
    s.clkPrev = gate[0];
    s.sysPhase = ~q.sysPhase;
    // gate wiring: g1 clock, g2 data, g3 reset, g4 set or second data; the SR mode sets on g1 or g2, resets on g3 or g4
    comb = 1'b0;
    case (q.ctrl[CTRL_MODE +: 3])
      MODE_AND_OR: begin
        comb = (gate[0] & gate[1]) | (gate[2] & gate[3]);
      end
      MODE_OR_XOR: begin
        comb = (gate[0] | gate[1]) ^ (gate[2] | gate[3]);
      end
      MODE_AND4: begin
        comb = &gate;
      end
      MODE_SR: begin
        // set wins when both are active
        if (gate[0] | gate[1]) begin
          s.store = 1'b1;
        end else if (gate[2] | gate[3]) begin
          s.store = 1'b0;
        end
        comb = s.store;
      end
      MODE_DFF_SR: begin
        // reset dominates set, both dominate the clock
        if (gate[2]) begin
          s.store = 1'b0;
        end else if (gate[3]) begin
          s.store = 1'b1;
        end else if (clkRise) begin
          s.store = gate[1];
        end
        comb = s.store;
      end
      MODE_DFF2_R: begin
        if (gate[2]) begin
          s.store = 1'b0;
        end else if (clkRise) begin
          s.store = gate[1] & gate[3];
        end
        comb = s.store;
      end
      MODE_JK_R: begin
        if (gate[2]) begin
          s.store = 1'b0;
        end else if (clkRise) begin
          case ({gate[1], gate[3]})
            2'b10:   s.store = 1'b1;
            2'b01:   s.store = 1'b0;
            2'b11:   s.store = ~q.store;
            default: s.store = q.store;
          endcase
        end
        comb = s.store;
      end
      MODE_LATCH: begin
        // transparent while gate 1 is high; a level, not an edge
        if (gate[2]) begin
          s.store = 1'b0;
        end else if (gate[3]) begin
          s.store = 1'b1;
        end else if (gate[0]) begin
          s.store = gate[1];
        end
        comb = s.store;
      end
      default: begin
        comb = 1'b0;
      end
    endcase
    // disabled cell holds zero and forgets its stored bit
    if (!q.ctrl[CTRL_ON]) begin
      s.store = 1'b0;
    end
    nextOut = q.ctrl[CTRL_ON] & (comb ^ q.ctrl[CTRL_POL]);
    s.cellOut = nextOut;
    // with both enables set every edge pulses, so software keeps one on
    s.irq = (nextOut & ~q.cellOut & q.ctrl[CTRL_RISE_IRQ_ENABLE])
          | (~nextOut & q.cellOut & q.ctrl[CTRL_FALL_IRQ_ENABLE]);
    // apb decode
    access = psel & penable;
    op = paddr[3:2];
    hit = 1'b1;
    cur = 32'h0000_0000;
    wmask = 32'h0000_0000;
    case ({paddr[ADDR_W-1:4], 4'h0})
      OFF_CTRL: begin
        cur = q.ctrl | ({31'h0, q.cellOut} << CTRL_OUT);
        wmask = CTRL_WMASK;
      end
      OFF_SEL: begin
        cur = q.sel & SEL_WMASK;
        wmask = SEL_WMASK;
      end
      OFF_GLS: begin
        cur = q.gls;
        wmask = GLS_WMASK;
      end
      default: begin
        hit = 1'b0;
      end
    endcase
    if (paddr[1:0] != 2'h0) begin
      hit = 1'b0;
    end
    newv = apply(cur, pwdata, wmask, op);
    // one wait state: ready rises on the second access cycle
    if (access && !q.ready) begin
      s.ready = 1'b1;
      s.slverr = ~hit;
      s.rdata = (hit && !pwrite) ? cur : 32'h0000_0000;
    end else begin
      s.ready = 1'b0;
      s.slverr = 1'b0;
      s.rdata = 32'h0000_0000;
    end
    // writes land on the edge where ready is seen high
    if (access && q.ready && pwrite && hit) begin
      case ({paddr[ADDR_W-1:4], 4'h0})
        OFF_CTRL: s.ctrl = newv & ~(32'h1 << CTRL_OUT);
        OFF_SEL:  s.sel = newv & SEL_WMASK;
        default:  s.gls = newv;
      endcase
    end
  end

  // state register; reset clears every configuration field
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      q <= '0;
    end else begin
      q <= s;
    end
  end

  // outputs come directly from the state register
  assign prdata = q.rdata;
  assign pready = q.ready;
  assign pslverr = q.slverr;
  assign cellOutput = q.cellOut;
  assign pinOutputEnable = q.ctrl[CTRL_OE];
  assign cellIrq = q.irq;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rstn);

  a_disable_zero: assert property (!q.ctrl[CTRL_ON] |=> !q.cellOut)
    else $error("disabled cell output not zero");
  a_output_invert: assert property ((q.ctrl[CTRL_ON] && q.ctrl[CTRL_POL]
      && q.ctrl[CTRL_MODE +: 3] == MODE_AND4) |=> (q.cellOut == !$past(&gate)))
    else $error("inverted output wrong");
  a_and_mode: assert property ((q.ctrl[CTRL_ON] && !q.ctrl[CTRL_POL]
      && q.ctrl[CTRL_MODE +: 3] == MODE_AND4) |=> (q.cellOut == $past(&gate)))
    else $error("and mode output wrong");
  a_andor_mode: assert property ((q.ctrl[CTRL_ON] && !q.ctrl[CTRL_POL]
      && q.ctrl[CTRL_MODE +: 3] == MODE_AND_OR)
      |=> (q.cellOut == $past((gate[0] & gate[1]) | (gate[2] & gate[3]))))
    else $error("and-or output wrong");
  a_orxor_mode: assert property ((q.ctrl[CTRL_ON] && !q.ctrl[CTRL_POL]
      && q.ctrl[CTRL_MODE +: 3] == MODE_OR_XOR)
      |=> (q.cellOut == $past((gate[0] | gate[1]) ^ (gate[2] | gate[3]))))
    else $error("or-xor output wrong");
  a_dff_reset: assert property ((q.ctrl[CTRL_ON] && !q.ctrl[CTRL_POL]
      && q.ctrl[CTRL_MODE +: 3] == MODE_DFF_SR && gate[2]) |=> !q.cellOut)
    else $error("flip-flop reset ignored");
  a_jk_toggle: assert property ((q.ctrl[CTRL_ON] && q.ctrl[CTRL_MODE +: 3] == MODE_JK_R
      && clkRise && gate[1] && gate[3] && !gate[2]) |=> (q.store != $past(q.store)))
    else $error("jk did not toggle");
  a_irq_rise: assert property ((q.cellOut && !$past(q.cellOut)
      && $past(q.ctrl[CTRL_RISE_IRQ_ENABLE])) |-> q.irq)
    else $error("rising edge interrupt missing");
  a_irq_cause: assert property (q.irq |-> (q.cellOut != $past(q.cellOut)))
    else $error("interrupt without output edge");
  a_sel_zero: assert property ((q.sel & ~SEL_WMASK) == 32'h0000_0000)
    else $error("unused select bits set");
  a_apb_wait: assert property ((psel && penable && !pready) |=> pready)
    else $error("apb ready late");
  // storage modes: one branch each, the set checks on the branch a wrong priority would skip; then the falling-edge irq
  a_sr_set: assert property ((q.ctrl[CTRL_ON] && q.ctrl[CTRL_MODE +: 3] == MODE_SR
      && (gate[0] || gate[1])) |=> q.store)
    else $error("sr latch did not set");
  a_dff_set: assert property ((q.ctrl[CTRL_ON] && q.ctrl[CTRL_MODE +: 3] == MODE_DFF_SR
      && !gate[2] && gate[3]) |=> q.store)
    else $error("flip-flop set ignored");
  a_dff2_capture: assert property ((q.ctrl[CTRL_ON]
      && q.ctrl[CTRL_MODE +: 3] == MODE_DFF2_R && clkRise && !gate[2])
      |=> (q.store == $past(gate[1] & gate[3])))
    else $error("two-input flip-flop capture wrong");
  a_latch_follow: assert property ((q.ctrl[CTRL_ON]
      && q.ctrl[CTRL_MODE +: 3] == MODE_LATCH && gate[0] && !gate[2] && !gate[3])
      |=> (q.store == $past(gate[1])))
    else $error("latch does not follow data");
  a_irq_fall: assert property ((!q.cellOut && $past(q.cellOut)
      && $past(q.ctrl[CTRL_FALL_IRQ_ENABLE])) |-> q.irq)
    else $error("falling edge interrupt missing");
endmodule
`default_nettype wire

// File: logic/lgc_pkg.sv
// constants and state type for the configurable logic cell
`default_nettype none
package lgc_pkg;
  localparam int          ADDR_W       = 12;
  // register word offsets, one block of four words per register
  localparam logic [11:0] OFF_CTRL     = 12'h000;
  localparam logic [11:0] OFF_SEL      = 12'h010;
  localparam logic [11:0] OFF_GLS      = 12'h020;
  // sub-word operations inside each block
  localparam logic [1:0]  OP_WRITE     = 2'h0;
  localparam logic [1:0]  OP_CLR       = 2'h1;
  localparam logic [1:0]  OP_SET       = 2'h2;
  localparam logic [1:0]  OP_INV       = 2'h3;
  // control field positions
  localparam int          CTRL_GPOL    = 16;
  localparam int          CTRL_ON      = 15;
  localparam int          CTRL_RISE_IRQ_ENABLE    = 11;
  localparam int          CTRL_FALL_IRQ_ENABLE    = 10;
  localparam int          CTRL_OE      = 7;
  localparam int          CTRL_OUT     = 6;
  localparam int          CTRL_POL     = 5;
  localparam int          CTRL_MODE    = 0;
  // select field positions
  localparam int          SEL_DS4      = 12;
  localparam int          SEL_DS3      = 8;
  localparam int          SEL_DS2      = 4;
  localparam int          SEL_DS1      = 0;
  // writable bit masks
  localparam logic [31:0] CTRL_WMASK   = 32'h000f_8ca7;
  localparam logic [31:0] SEL_WMASK    = 32'h0000_7777;
  localparam logic [31:0] GLS_WMASK    = 32'hffff_ffff;
  // reset values
  localparam logic [31:0] CTRL_RESET   = 32'h0000_0000;
  localparam logic [31:0] SEL_RESET    = 32'h0000_0000;
  localparam logic [31:0] GLS_RESET    = 32'h0000_0000;
  // core function codes
  localparam logic [2:0]  MODE_AND_OR  = 3'h0;
  localparam logic [2:0]  MODE_OR_XOR  = 3'h1;
  localparam logic [2:0]  MODE_AND4    = 3'h2;
  localparam logic [2:0]  MODE_SR      = 3'h3;
  localparam logic [2:0]  MODE_DFF_SR  = 3'h4;
  localparam logic [2:0]  MODE_DFF2_R  = 3'h5;
  localparam logic [2:0]  MODE_JK_R    = 3'h6;
  localparam logic [2:0]  MODE_LATCH   = 3'h7;

  // whole state of the cell
  typedef struct packed {
    logic [31:0] ctrl;      // cell_control, status bit kept apart
    logic [31:0] sel;       // input_mux_select
    logic [31:0] gls;       // gate_source_enable
    logic        store;     // latch or flip-flop content
    logic        clkPrev;   // gate 1 of the previous cycle
    logic        sysPhase;  // sampled image of the system clock
    logic        cellOut;   // final output, also cell_output_status
    logic        irq;       // edge interrupt pulse
    logic [31:0] rdata;     // apb read data
    logic        ready;     // apb ready
    logic        slverr;    // apb error
  } lgc_state_t;
endpackage
`default_nettype wire

// File: verification/lgc_src_model.sv
// source model: on-chip peripherals and pins feeding the cell's muxes
`default_nettype none
module lgc_src_model (
  input  wire logic        clk,    // system clock
  input  wire logic [21:0] srcCmd, // levels the bench wants to see
  output var  logic [21:0] srcs    // levels presented to the cell
);
  timeunit 1ns;
  timeprecision 1ns;
  // peripherals present synchronous levels, so a level moves only one edge after it is asked for
  always_ff @(posedge clk) begin
    srcs <= srcCmd;
  end
endmodule
`default_nettype wire

// File: verification/test_configurable_logic_cell.sv
// self-checking bench for the configurable logic cell
`default_nettype none
module test_configurable_logic_cell;
  timeunit 1ns;
  timeprecision 1ns;
  import lgc_pkg::*;
  typedef struct packed {
    logic [2:0] mode; // core function code
    logic       pol;  // output invert
    logic       en;   // cell enable and pin enable
    logic [3:0] ginv; // gate invert 4..1
    logic [1:0] ie;   // rise, fall irq enable; never both at once
    logic [3:0] src;  // gate sources 4..1
    logic       exp;  // expected output
    logic [1:0] nirq; // expected irq pulses
  } lgc_row_t;
  // rows run in order: the storage modes rely on the state that earlier rows left
  localparam lgc_row_t ROWS [31] = '{
    '{3'd0,1'b0,1'b1,4'h0,2'd0,4'b0011,1'b1,2'd0}, '{3'd0,1'b0,1'b1,4'h0,2'd0,4'b0101,1'b0,2'd0},
    '{3'd1,1'b0,1'b1,4'h0,2'd0,4'b0001,1'b1,2'd0}, '{3'd1,1'b0,1'b1,4'h0,2'd0,4'b0101,1'b0,2'd0},
    '{3'd2,1'b0,1'b1,4'h0,2'd2,4'b1111,1'b1,2'd1}, '{3'd2,1'b0,1'b1,4'h0,2'd1,4'b1111,1'b1,2'd0},
    '{3'd2,1'b0,1'b1,4'h8,2'd1,4'b0111,1'b1,2'd1}, '{3'd2,1'b1,1'b1,4'h0,2'd0,4'b1111,1'b0,2'd1},
    '{3'd2,1'b1,1'b0,4'h0,2'd0,4'b1111,1'b0,2'd0}, '{3'd3,1'b0,1'b1,4'h0,2'd0,4'b0001,1'b1,2'd0},
    '{3'd3,1'b0,1'b1,4'h0,2'd0,4'b0000,1'b1,2'd0}, '{3'd3,1'b0,1'b1,4'h0,2'd0,4'b0100,1'b0,2'd0},
    '{3'd3,1'b0,1'b0,4'h0,2'd0,4'b0000,1'b0,2'd0}, '{3'd4,1'b0,1'b1,4'h0,2'd0,4'b0010,1'b0,2'd0},
    '{3'd4,1'b0,1'b1,4'h0,2'd0,4'b0011,1'b1,2'd0}, '{3'd4,1'b0,1'b1,4'h0,2'd0,4'b0010,1'b1,2'd0},
    '{3'd4,1'b0,1'b1,4'h0,2'd0,4'b0100,1'b0,2'd0}, '{3'd4,1'b0,1'b1,4'h0,2'd0,4'b1000,1'b1,2'd0},
    '{3'd4,1'b0,1'b0,4'h0,2'd0,4'b0000,1'b0,2'd0}, '{3'd5,1'b0,1'b1,4'h0,2'd0,4'b1010,1'b0,2'd0},
    '{3'd5,1'b0,1'b1,4'h0,2'd0,4'b1011,1'b1,2'd0}, '{3'd5,1'b0,1'b1,4'h0,2'd0,4'b0100,1'b0,2'd0},
    '{3'd6,1'b0,1'b1,4'h0,2'd0,4'b0010,1'b0,2'd0}, '{3'd6,1'b0,1'b1,4'h0,2'd0,4'b0011,1'b1,2'd0},
    '{3'd6,1'b0,1'b1,4'h0,2'd0,4'b1010,1'b1,2'd0}, '{3'd6,1'b0,1'b1,4'h0,2'd0,4'b1011,1'b0,2'd0},
    '{3'd7,1'b0,1'b1,4'h0,2'd0,4'b0011,1'b1,2'd0}, '{3'd7,1'b0,1'b1,4'h0,2'd0,4'b0001,1'b0,2'd0},
    '{3'd7,1'b0,1'b1,4'h0,2'd0,4'b0011,1'b1,2'd0}, '{3'd7,1'b0,1'b1,4'h0,2'd0,4'b0010,1'b1,2'd0},
    '{3'd7,1'b0,1'b1,4'h0,2'd0,4'b0110,1'b0,2'd0}};
  // source index per mux and code; 31 reserved, 30 not drivable from here
  localparam logic [4:0] MUX_SRC [4][8] = '{
    '{5'd0, 5'd30, 5'd20, 5'd19, 5'd18, 5'd7, 5'd8, 5'd9},
    '{5'd1, 5'd21, 5'd15, 5'd14, 5'd17, 5'd31, 5'd6, 5'd31},
    '{5'd0, 5'd30, 5'd16, 5'd12, 5'd13, 5'd4, 5'd3, 5'd2},
    '{5'd1, 5'd21, 5'd5, 5'd11, 5'd31, 5'd10, 5'd6, 5'd2}};
  logic        clk, rstn, psel, penable, pwrite, pready, pslverr, erv;
  logic        cellOutput, pinOutputEnable, cellIrq;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rdv;
  logic [21:0] srcCmd, srcs;
  logic [4:0]  idx;
  logic        prevOut;
  int          mismatches, cmp_count, irqSeen, base;

  lgc_src_model i_lgc_src_model (.clk(clk), .srcCmd(srcCmd), .srcs(srcs));
  lgc_cell i_lgc_cell (.clk(clk), .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .inputPinA(srcs[0]), .inputPinB(srcs[1]), .timer3Match(srcs[2]), .timer2Match(srcs[3]),
    .timer2Output(srcs[4]), .timer3Output(srcs[5]), .multiTimerMatch(srcs[6]),
    .multiTimerOutA(srcs[7]), .multiTimerOutB(srcs[8]), .multiTimerOutC(srcs[9]),
    .calendarEvent(srcs[10]), .serialDataIn(srcs[11]), .serialDataOut(srcs[12]),
    .uartRxIn(srcs[13]), .uartTxOut(srcs[14]), .comparator1Out(srcs[15]),
    .comparator2Out(srcs[16]), .adcEocEvent(srcs[17]), .referenceClockOut(srcs[18]),
    .lowPowerRcClock(srcs[19]), .secondaryOscillator(srcs[20]), .otherCellOut(srcs[21]),
    .cellOutput(cellOutput), .pinOutputEnable(pinOutputEnable), .cellIrq(cellIrq));

  // 10 MHz system clock
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  // count irq pulses; the bench compares deltas per row
  always @(posedge clk) begin
    if (cellIrq === 1'b1) irqSeen <= irqSeen + 1;
  end
  task automatic tick(input int k);
    repeat (k) @(posedge clk);
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] want);
    cmp_count++;
    if (seen !== want) begin
      mismatches++;
      $display("[FAIL] %0t: saw %h, expected %h", $time, seen, want);
    end
  endtask
  // one apb transfer; request held until pready is seen, only the watchdog ends a hang
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
    @(posedge clk);
    {psel, pwrite, paddr, pwdata} <= {1'b1, wr, a, wd};
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rdv = prdata;
    erv = pslverr;
    {psel, penable} <= 2'b00;
  endtask
  // gates 1..4 fed by pin a, comparator 1, comparator 2, timer 3 match
  function automatic logic [21:0] gv(input logic [3:0] s);
    gv = '0;
    gv[0] = s[0];
    gv[15] = s[1];
    gv[16] = s[2];
    gv[2] = s[3];
  endfunction
  task automatic summarize();
    $display("comparisons %0d, mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  // watchdog: the whole run needs some eight hundred cycles, so this leaves ample margin
  initial begin
    tick(30000);
    mismatches++;
    summarize();
  end

  initial begin
    {rstn, psel, penable, pwrite, paddr, pwdata, srcCmd} = '0;
    tick(8);
    rstn <= 1'b1;
    apb(1'b1, OFF_SEL, 32'h0000_7220);
    apb(1'b1, OFF_GLS, 32'h8020_0802);
    // function table: each row zeroes sources, writes control, applies sources, checks
    foreach (ROWS[i]) begin
      base = irqSeen;
      srcCmd <= '0;
      tick(3);
      apb(1'b1, OFF_CTRL, {12'h000, ROWS[i].ginv, ROWS[i].en, 3'h0, ROWS[i].ie, 2'h0,
                           ROWS[i].en, 1'b0, ROWS[i].pol, 2'h0, ROWS[i].mode});
      srcCmd <= gv(ROWS[i].src);
      tick(4);
      chk({31'h0, cellOutput}, {31'h0, ROWS[i].exp});
      chk({31'h0, pinOutputEnable}, {31'h0, ROWS[i].en});
      chk(32'(irqSeen - base), {30'h0, ROWS[i].nirq});
    end
    $display("function rows done");
    // true and inverted copy of one source in a gate: always high
    apb(1'b1, OFF_GLS, 32'h0000_0003);
    apb(1'b1, OFF_CTRL, 32'h0000_8001);
    tick(4);
    chk({31'h0, cellOutput}, 32'h1);
    // reset in mid-run clears output, control and gate sources; select reads back only its writable bits
    rstn <= 1'b0;
    tick(2);
    chk({31'h0, cellOutput}, 32'h0);
    rstn <= 1'b1;
    apb(1'b0, OFF_CTRL, 32'h0);
    chk(rdv, CTRL_RESET);
    apb(1'b0, OFF_GLS, 32'h0);
    chk(rdv, GLS_RESET);
    apb(1'b1, OFF_SEL, 32'hffff_ffff);
    apb(1'b0, OFF_SEL, 32'h0);
    chk(rdv, 32'h0000_7777);
    // clear, set and invert sub-words touch only the writable select bits
    apb(1'b1, OFF_SEL + 12'h004, 32'h0000_0707);
    apb(1'b0, OFF_SEL, 32'h0);
    chk(rdv, 32'h0000_7070);
    apb(1'b1, OFF_SEL + 12'h008, 32'h0000_0007);
    apb(1'b1, OFF_SEL + 12'h00c, 32'hffff_7000);
    apb(1'b0, OFF_SEL + 12'h00c, 32'h0);
    chk(rdv, 32'h0000_0077);
    apb(1'b0, 12'h040, 32'h0);
    chk({31'h0, erv}, 32'h1);
    $display("reset and register tests done");
    // each mux code but system clock and feedback: only the chosen source high gives 1, only it low gives 0; reserved codes give 0
    apb(1'b1, OFF_CTRL, 32'h0000_8001);
    for (int m = 0; m < 4; m++) begin
      apb(1'b1, OFF_GLS, 32'h1 << (2 * m + 1));
      for (int c = 0; c < 8; c++) begin
        idx = MUX_SRC[m][c];
        if (idx != 5'd30) begin
          apb(1'b1, OFF_SEL, 32'(c) << (4 * m));
          srcCmd <= (idx == 5'd31) ? '1 : 22'h1 << idx;
          tick(4);
          chk({31'h0, cellOutput}, {31'h0, idx != 5'd31});
          srcCmd <= ~(22'h1 << idx);
          tick(4);
          if (idx != 5'd31) chk({31'h0, cellOutput}, 32'h0);
        end
      end
    end
    // system clock code and own-output feedback with inversion both toggle every cycle
    apb(1'b1, OFF_SEL, 32'h0000_0001);
    apb(1'b1, OFF_GLS, 32'h0000_0002);
    tick(2);
    prevOut = cellOutput;
    tick(1);
    chk({31'h0, cellOutput ^ prevOut}, 32'h1);
    apb(1'b1, OFF_SEL, 32'h0000_0100);
    apb(1'b1, OFF_GLS, 32'h0000_0020);
    apb(1'b1, OFF_CTRL, 32'h0000_8021);
    tick(2);
    prevOut = cellOutput;
    tick(1);
    chk({31'h0, cellOutput ^ prevOut}, 32'h1);
    $display("mux source tests done");
    summarize();
  end
endmodule
`default_nettype wire
